/* crs_pkg.sv */
// Constants and types for the card reset and stream return block
`default_nettype none
package crs_pkg;
  localparam int CLOCK_HZ = 10_000_000;
  localparam int CLOCK_NS = 1_000_000_000 / CLOCK_HZ;
  // Longest time from reset negate to outputs valid, in ms
  localparam int OUT_VALID_MS = 20;
  localparam int OUT_VALID_CYCLES = (OUT_VALID_MS * 1_000_000) / CLOCK_NS;
  // Outputs are declared valid well inside the limit, in cycles
  localparam int OUT_VALID_DELAY = 16;
  // Fixed return latency, in input clock periods
  localparam int RETURN_LATENCY = 4;
  localparam int BYTE_W = 8;
  localparam int BUF_DEPTH = 2;
  localparam logic [BYTE_W-1:0] BYTE_RESET = 8'h00;
  typedef enum logic [2:0] {
    CRS_POWERED = 3'h1,
    CRS_IN_RESET = 3'h2,
    CRS_RUNNING = 3'h4
  } crs_state_t;
endpackage : crs_pkg
`default_nettype wire

/* crs_card_reset_stream.sv */
// Card reset sequencing and transport stream return path
//
// Contract
// - Outputs valid within 20 ms of negate
// - Inputs high impedance until first reset
// - Outputs high impedance until reset negated
// - Fixed return latency within one clock
// - Packets returned in received order
// - Output clock derived from input clock
// - Works at 27 MHz plus minus 1000ppm; the 10 MHz sampling clock cannot follow a link that fast
`default_nettype none
module crs_card_reset_stream
  import crs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic streamInClock,
  input wire logic [BYTE_W-1:0] streamInByte,
  input wire logic streamInPacketStart,
  output logic streamOutClock,
  output logic streamOutClockEn,
  output logic [BYTE_W-1:0] streamOutByte,
  output logic streamOutPacketStart,
  output logic streamOutEn,
  output logic inputsEnabled,
  output logic outputsValid,
  output logic stallSeen
);
  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for the pins from the far side
  logic [2:0] clkSync_reg;
  logic [2:0] clkSync_next;
  logic [BYTE_W:0] datSync1_reg;
  logic [BYTE_W:0] datSync1_next;
  logic [BYTE_W:0] datSync2_reg;
  logic [BYTE_W:0] datSync2_next;
  logic inRise;

  always_comb begin
    clkSync_next = {clkSync_reg[1:0], streamInClock};
    datSync1_next = {streamInPacketStart, streamInByte};
    datSync2_next = datSync1_reg;
  end

  always_ff @(posedge clock) begin
    clkSync_reg <= clkSync_next;
    datSync1_reg <= datSync1_next;
    datSync2_reg <= datSync2_next;
  end

  // Edge found on stages two and three only
  // Link half period must exceed one system clock or edges are lost
  assign inRise = clkSync_reg[1] & ~clkSync_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // Power and reset sequence
  crs_state_t state_reg;
  crs_state_t state_next;
  logic [4:0] validCnt_reg;
  logic [4:0] validCnt_next;
  logic valid_reg;
  logic valid_next;
  logic inEn_reg;
  logic inEn_next;

  always_comb begin
    state_next = state_reg;
    validCnt_next = validCnt_reg;
    valid_next = valid_reg;
    case (state_reg)
      CRS_POWERED: begin
        // Pins must not wake on their own before a reset
        state_next = CRS_POWERED;
      end
      CRS_IN_RESET: begin
        state_next = CRS_RUNNING;
      end
      CRS_RUNNING: begin
        if (validCnt_reg != 5'(OUT_VALID_DELAY)) begin
          validCnt_next = validCnt_reg + 5'h01;
        end else begin
          valid_next = 1'b1;
        end
      end
      default: state_next = CRS_POWERED;
    endcase
    inEn_next = (state_next != CRS_POWERED);
  end

  // Power-up content is modelled by reset itself; first reset enables inputs
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= CRS_IN_RESET;
      validCnt_reg <= 5'h00;
      valid_reg <= 1'b0;
      inEn_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      validCnt_reg <= validCnt_next;
      valid_reg <= valid_next;
      inEn_reg <= inEn_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input capture into a delay line of fixed length
  logic [BYTE_W:0] pipe_reg [RETURN_LATENCY];
  logic [BYTE_W:0] pipe_next [RETURN_LATENCY];
  logic bufInReady;
  logic pipeAdvance;

  // Stall freezes the line whole, so order and spacing hold
  assign pipeAdvance = inRise & bufInReady;

  always_comb begin
    for (int i = 0; i < RETURN_LATENCY; i++) begin
      pipe_next[i] = pipe_reg[i];
    end
    if (pipeAdvance) begin
      pipe_next[0] = datSync2_reg;
      for (int i = 1; i < RETURN_LATENCY; i++) begin
        pipe_next[i] = pipe_reg[i-1];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < RETURN_LATENCY; i++) begin
        pipe_reg[i] <= {1'b0, BYTE_RESET};
      end
    end else begin
      for (int i = 0; i < RETURN_LATENCY; i++) begin
        pipe_reg[i] <= pipe_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer before the output pins
  logic [BYTE_W:0] buf_reg [BUF_DEPTH];
  logic [BYTE_W:0] buf_next [BUF_DEPTH];
  logic wr_reg;
  logic wr_next;
  logic rd_reg;
  logic rd_next;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic bufInValid;
  logic bufOutValid;
  logic bufOutReady;
  logic pushNow;
  logic popNow;

  assign bufInValid = inRise & valid_reg;
  assign bufInReady = (cnt_reg != 2'(BUF_DEPTH));
  assign bufOutValid = (cnt_reg != 2'h0);
  // Receiver side takes one word per input clock edge
  assign bufOutReady = inRise;
  assign pushNow = bufInValid & bufInReady;
  assign popNow = bufOutValid & bufOutReady;

  always_comb begin
    for (int i = 0; i < BUF_DEPTH; i++) begin
      buf_next[i] = buf_reg[i];
    end
    wr_next = wr_reg;
    rd_next = rd_reg;
    cnt_next = cnt_reg;
    if (pushNow) begin
      buf_next[wr_reg] = pipe_reg[RETURN_LATENCY-1];
      wr_next = ~wr_reg;
    end
    if (popNow) begin
      rd_next = ~rd_reg;
    end
    cnt_next = cnt_reg + 2'(pushNow) - 2'(popNow);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_reg[i] <= {1'b0, BYTE_RESET};
      end
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_reg[i] <= buf_next[i];
      end
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      cnt_reg <= cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins
  logic [BYTE_W:0] out_reg;
  logic [BYTE_W:0] out_next;
  logic oclk_reg;
  logic oclk_next;
  logic stall_reg;
  logic stall_next;

  always_comb begin
    out_next = out_reg;
    if (popNow) begin
      out_next = buf_reg[rd_reg];
    end
    // Output clock follows the input clock, delayed but same rate
    oclk_next = clkSync_reg[2];
    stall_next = stall_reg | (bufInValid & ~bufInReady);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      out_reg <= {1'b0, BYTE_RESET};
      oclk_reg <= 1'b0;
      stall_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oclk_reg <= oclk_next;
      stall_reg <= stall_next;
    end
  end

  assign streamOutClock = oclk_reg;
  assign streamOutByte = out_reg[BYTE_W-1:0];
  assign streamOutPacketStart = out_reg[BYTE_W];
  assign streamOutEn = valid_reg;
  assign streamOutClockEn = valid_reg;
  assign inputsEnabled = inEn_reg;
  assign outputsValid = valid_reg;
  assign stallSeen = stall_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_out_valid_time;
    @(posedge clock) disable iff (rst)
      $fell(state_reg == CRS_IN_RESET) |-> ##[1:20] valid_reg;
  endproperty
  a_out_valid_time: assert property (p_out_valid_time) else $error("outputs not valid in time");

  property p_hiz_in_reset;
    @(posedge clock) rst |=> !streamOutEn;
  endproperty
  a_hiz_in_reset: assert property (p_hiz_in_reset) else $error("output driven during reset");

  property p_inputs_on;
    @(posedge clock) rst |=> inputsEnabled;
  endproperty
  a_inputs_on: assert property (p_inputs_on) else $error("inputs not enabled after reset");

  property p_buf_order;
    @(posedge clock) disable iff (rst)
      popNow && pushNow && cnt_reg == 2'h1 |=> out_reg == $past(buf_reg[~wr_reg]);
  endproperty
  a_buf_order: assert property (p_buf_order) else $error("buffer order broken");

  property p_pipe_shift;
    @(posedge clock) disable iff (rst)
      pipeAdvance |=> pipe_reg[1] == $past(pipe_reg[0]);
  endproperty
  a_pipe_shift: assert property (p_pipe_shift) else $error("delay line did not shift");

  property p_clock_follow;
    @(posedge clock) disable iff (rst)
      inRise |=> ##1 streamOutClock;
  endproperty
  a_clock_follow: assert property (p_clock_follow) else $error("output clock lost edge");

  property p_count_bound;
    @(posedge clock) disable iff (rst) cnt_reg <= 2'(BUF_DEPTH);
  endproperty
  a_count_bound: assert property (p_count_bound) else $error("buffer overfilled");

  property p_sample_edge;
    @(posedge clock) disable iff (rst)
      pipeAdvance |=> pipe_reg[0] == $past(datSync2_reg);
  endproperty
  a_sample_edge: assert property (p_sample_edge) else $error("byte not sampled on edge");

  c_valid: cover property (@(posedge clock) $rose(valid_reg));
  c_full: cover property (@(posedge clock) cnt_reg == 2'(BUF_DEPTH));
  c_start: cover property (@(posedge clock) $rose(streamOutPacketStart));
endmodule : crs_card_reset_stream
`default_nettype wire

/* crs_host_model.sv */
// Host side model: link clock and numbered stream bytes
`default_nettype none
module crs_host_model
  import crs_pkg::*;
(
  input wire logic clock,
  input wire logic run,
  output logic streamInClock,
  output logic [BYTE_W-1:0] streamInByte,
  output logic streamInPacketStart
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase = 2'h0;
  logic [BYTE_W-1:0] count = 8'h00;
  logic linkClock = 1'b0;
  // Link clock of 8 system cycles, held low while run is low
  always @(negedge clock) begin
    if (run) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        linkClock <= ~linkClock;
        if (linkClock) begin
          count <= count + 8'h01;
        end
      end
    end
  end
  // Pulled-down lines read low when idle
  assign streamInClock = run & linkClock;
  assign streamInByte = run ? count : 8'h00;
  assign streamInPacketStart = run & (count[2:0] == 3'h0);
endmodule : crs_host_model
`default_nettype wire

/* crs_card_reset_stream_tb_top.sv */
// Testbench for the card reset and stream return block
`default_nettype none
module crs_card_reset_stream_tb_top
  import crs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Mid-run reset pulse of 10 us at the 100 ns clock
  localparam int RESET_HOLD = 100;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic streamInClock, streamInPacketStart, streamOutClock, streamOutClockEn;
  logic streamOutPacketStart, streamOutEn, inputsEnabled, outputsValid, stallSeen;
  logic [BYTE_W-1:0] streamInByte, streamOutByte;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int inRises = 0;
  int outRises = 0;
  initial begin
    forever #50 clock = ~clock;
  end
  crs_host_model crs_host_model_i (.clock(clock), .run(run), .streamInClock(streamInClock),
    .streamInByte(streamInByte), .streamInPacketStart(streamInPacketStart));
  crs_card_reset_stream crs_card_reset_stream_i (.clock(clock), .rst(rst), .streamInClock(streamInClock),
    .streamInByte(streamInByte), .streamInPacketStart(streamInPacketStart), .streamOutClock(streamOutClock),
    .streamOutClockEn(streamOutClockEn), .streamOutByte(streamOutByte),
    .streamOutPacketStart(streamOutPacketStart), .streamOutEn(streamOutEn), .inputsEnabled(inputsEnabled),
    .outputsValid(outputsValid), .stallSeen(stallSeen));
  always @(posedge streamInClock) inRises++;
  always @(posedge streamOutClock) outRises++;
  task automatic summarize();
    if (miscompares == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  // Reset pulse, then wait for outputs to come up
  task automatic t_reset(input int hold);
    int n;
    rst = 1'b1;
    run = 1'b1;
    repeat (hold) @(negedge clock);
    check(streamOutEn === 1'b0 && streamOutClockEn === 1'b0 && outputsValid === 1'b0, "driven in reset");
    check(inputsEnabled === 1'b1, "inputs idle after reset");
    rst = 1'b0;
    n = 0;
    while (outputsValid !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    check(outputsValid === 1'b1 && n <= OUT_VALID_CYCLES, "outputs late");
    check(streamOutEn === 1'b1 && streamOutClockEn === 1'b1, "enables low");
  endtask : t_reset
  // Numbered bytes must come back at one constant distance
  task automatic t_stream(input int edges);
    logic [BYTE_W-1:0] lag;
    int inStart;
    int outStart;
    repeat (12) @(posedge streamInClock);
    lag = streamInByte - streamOutByte;
    inStart = inRises;
    outStart = outRises;
    repeat (edges) begin
      @(posedge streamInClock);
      check((streamInByte - streamOutByte) === lag, "latency moved");
      check(streamOutPacketStart === (streamOutByte[2:0] == 3'h0), "start flag split");
    end
    // Delay line, buffer stage, and one more input edge before the bench looks
    check(lag === 8'(RETURN_LATENCY + 2), "latency out of range");
    check((outRises - outStart) - (inRises - inStart) inside {-1, 0, 1}, "clock rate differs");
    check(stallSeen === 1'b0, "word lost to stall");
  endtask : t_stream
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      summarize();
    end
  end
  initial begin
    @(negedge clock);
    t_reset(2);
    t_stream(40);
    t_reset(RESET_HOLD);
    t_stream(20);
    summarize();
  end
endmodule : crs_card_reset_stream_tb_top
`default_nettype wire
